//--- rtl/pirq_pkg.sv
// Package: register map, field positions and shared types of the interrupt flag block
package pirq_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00; // irq_control_reg
    localparam logic [7:0] OFS_ENABLE_1 = 8'h04; // peripheral_irq_enable_1
    localparam logic [7:0] OFS_ENABLE_2 = 8'h08; // peripheral_irq_enable_2
    localparam logic [7:0] OFS_REQUEST_1 = 8'h0c; // peripheral_irq_request_1
    localparam logic [7:0] OFS_REQUEST_2 = 8'h10; // capture/compare-two flag
    localparam logic [7:0] OFS_EVENT_STAT = 8'h14; // sticky event status
    localparam logic [7:0] OFS_EVENT_MASK = 8'h18; // event status mask

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTL_GLOBAL_EN_BIT = 7;
    localparam int CTL_GROUP_EN_BIT = 6;
    localparam int CTL_T0_EN_BIT = 5;
    localparam int CTL_T0_FLAG_BIT = 2;
    localparam int REQ_GATE_BIT = 7;
    localparam int REQ_ADC_BIT = 6;
    localparam int REQ_RX_BIT = 5;
    localparam int REQ_TX_BIT = 4;
    localparam int REQ_SYNC_BIT = 3;
    localparam int REQ_CC1_BIT = 2;
    localparam int REQ_TMR2_BIT = 1;
    localparam int REQ_TIMER_ONE_COUNT_REG_BIT = 0;
    localparam int EV_W = 10;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_REQUEST = 8'h00;
    localparam logic [9:0] RST_EVENT = 10'h000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        CC_CAPTURE = 2'b00,
        CC_COMPARE = 2'b01,
        CC_PWM = 2'b11
    } capcmp_mode_t;

    typedef struct packed {
        logic timer_zero_roll;
        logic gate_active;
        logic adc_done;
        logic rx_full;
        logic tx_empty;
        logic sync_done;
        logic cc1_capture;
        logic cc1_match;
        logic timer_two_match;
        logic timer_one_roll;
        logic cc2_capture;
        logic cc2_match;
    } periph_events_t;

endpackage

//--- rtl/sticky_flag.sv
// Sticky flag cell: set wins over clear
`timescale 1ns/1ps
module sticky_flag (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set,
    input wire logic clr,
    input wire logic wr_en,
    input wire logic wr_val,
    output logic flag_q
);
    // Event set dominates software write or clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end else if (wr_en) begin
            flag_q <= wr_val;
        end
    end
endmodule

//--- rtl/periph_irq.sv
// Peripheral interrupt flags, enables and request logic with APB slave
//
// Function
// (R1) Timer-zero rollover sets its overflow flag
// (R2) Software initialises timer zero before clearing flag
// (R3) Peripheral group enable gates all peripheral sources; event_irq_q is not gated by it
// (R4) Flags set regardless of any enable
// (R5) Software clears flag before enabling its source
// (R6) Enable register one: eight RW bits, reset zero
// (R7) Enable register two: only bit 0 implemented
// (R8) Gate flag reads one while gate inactive
// (R9) ADC done flag sticky until software clear
// (R10) Receive flag follows full buffer, read-only
// (R11) Transmit flag follows empty buffer, read-only
// (R12) Sync port done flag sticky until clear
// (R13) Capture sets capcmp-one flag, sticky
// (R14) Compare match sets flag; PWM mode unused
// (R15) Timer-two period match sets sticky flag
// (R16) Timer-one overflow sets sticky flag
// (R17) Global enable gates irq_request_q; event_irq_q is not gated by it
// (R18) Request is global AND grouped enabled flags
`timescale 1ns/1ps
module periph_irq (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pirq_pkg::periph_events_t events,
    input wire pirq_pkg::capcmp_mode_t cc1_mode,
    input wire pirq_pkg::capcmp_mode_t cc2_mode,
    input wire logic rx_data_read,
    input wire logic tx_data_write,
    output logic irq_request_q,
    output logic event_irq_q
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    assign acc = psel & penable;
    assign wr = acc & pwrite & pready; // Write lands only at the completing edge
    assign rd = acc & ~pwrite;
    assign mapped = (paddr == pirq_pkg::OFS_CONTROL) || (paddr == pirq_pkg::OFS_ENABLE_1)
        || (paddr == pirq_pkg::OFS_ENABLE_2) || (paddr == pirq_pkg::OFS_REQUEST_1)
        || (paddr == pirq_pkg::OFS_REQUEST_2) || (paddr == pirq_pkg::OFS_EVENT_STAT)
        || (paddr == pirq_pkg::OFS_EVENT_MASK);

    logic wr_ctl;
    logic wr_en1;
    logic wr_en2;
    logic wr_req1;
    logic wr_req2;
    assign wr_ctl = wr && (paddr == pirq_pkg::OFS_CONTROL);
    assign wr_en1 = wr && (paddr == pirq_pkg::OFS_ENABLE_1);
    assign wr_en2 = wr && (paddr == pirq_pkg::OFS_ENABLE_2);
    assign wr_req1 = wr && (paddr == pirq_pkg::OFS_REQUEST_1);
    assign wr_req2 = wr && (paddr == pirq_pkg::OFS_REQUEST_2);

    // ----------------------------------------
    // Control register bits
    // ----------------------------------------
    logic global_irq_enable_q;
    logic peripheral_group_enable_q;
    logic timer_zero_enable_q;
    logic timer_zero_overflow_flag;

    // Global, group and timer-zero enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable_q <= pirq_pkg::RST_CONTROL[pirq_pkg::CTL_GLOBAL_EN_BIT];
            peripheral_group_enable_q <= pirq_pkg::RST_CONTROL[pirq_pkg::CTL_GROUP_EN_BIT];
            timer_zero_enable_q <= pirq_pkg::RST_CONTROL[pirq_pkg::CTL_T0_EN_BIT];
        end else if (wr_ctl) begin
            global_irq_enable_q <= pwdata[pirq_pkg::CTL_GLOBAL_EN_BIT];
            peripheral_group_enable_q <= pwdata[pirq_pkg::CTL_GROUP_EN_BIT];
            timer_zero_enable_q <= pwdata[pirq_pkg::CTL_T0_EN_BIT];
        end
    end

    // Timer-zero rollover flag; set regardless of enables
    sticky_flag u_t0 ( // R1 R4
        .pclk(pclk),
        .presetn(presetn),
        .set(events.timer_zero_roll),
        .clr(1'b0),
        .wr_en(wr_ctl),
        .wr_val(pwdata[pirq_pkg::CTL_T0_FLAG_BIT]),
        .flag_q(timer_zero_overflow_flag)
    );

    // ----------------------------------------
    // Enable registers
    // ----------------------------------------
    logic [7:0] peripheral_irq_enable_1_q;
    logic capcmp_two_enable_q;

    // Eight enables of register one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_irq_enable_1_q <= pirq_pkg::RST_ENABLE; // R6
        end else if (wr_en1) begin
            peripheral_irq_enable_1_q <= pwdata[7:0]; // R6
        end
    end

    // Single implemented enable of register two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capcmp_two_enable_q <= pirq_pkg::RST_ENABLE[0]; // R7
        end else if (wr_en2) begin
            capcmp_two_enable_q <= pwdata[0]; // R7
        end
    end

    // ----------------------------------------
    // Request flags
    // ----------------------------------------
    logic timer_one_gate_flag;
    logic serial_rx_full_flag;
    logic serial_tx_empty_flag;
    logic adc_done_flag;
    logic sync_port_done_flag;
    logic capcmp_one_flag;
    logic timer_two_match_flag;
    logic timer_one_overflow_flag;
    logic capcmp_two_flag;
    logic cc1_set;
    logic cc2_set;

    // Gate flag and serial flags mirror buffer and gate state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_gate_flag <= pirq_pkg::RST_REQUEST[pirq_pkg::REQ_GATE_BIT];
            serial_rx_full_flag <= pirq_pkg::RST_REQUEST[pirq_pkg::REQ_RX_BIT];
            serial_tx_empty_flag <= pirq_pkg::RST_REQUEST[pirq_pkg::REQ_TX_BIT];
        end else begin
            timer_one_gate_flag <= ~events.gate_active; // R8
            serial_rx_full_flag <= events.rx_full & ~rx_data_read; // R10
            serial_tx_empty_flag <= events.tx_empty & ~tx_data_write; // R11
        end
    end

    // Capture/compare events count only in their active mode
    always_comb begin
        cc1_set = 1'b0;
        cc2_set = 1'b0;
        case (cc1_mode)
            pirq_pkg::CC_CAPTURE: cc1_set = events.cc1_capture; // R13
            pirq_pkg::CC_COMPARE: cc1_set = events.cc1_match; // R14
            default: cc1_set = 1'b0; // R14
        endcase
        case (cc2_mode)
            pirq_pkg::CC_CAPTURE: cc2_set = events.cc2_capture;
            pirq_pkg::CC_COMPARE: cc2_set = events.cc2_match;
            default: cc2_set = 1'b0;
        endcase
    end

    // Sticky flags: set wins over a software write in the same cycle
    sticky_flag u_adc ( // R9 R4
        .pclk(pclk),
        .presetn(presetn),
        .set(events.adc_done),
        .clr(1'b0),
        .wr_en(wr_req1),
        .wr_val(pwdata[pirq_pkg::REQ_ADC_BIT]),
        .flag_q(adc_done_flag)
    );
    sticky_flag u_sync ( // R12
        .pclk(pclk),
        .presetn(presetn),
        .set(events.sync_done),
        .clr(1'b0),
        .wr_en(wr_req1),
        .wr_val(pwdata[pirq_pkg::REQ_SYNC_BIT]),
        .flag_q(sync_port_done_flag)
    );
    sticky_flag u_cc1 ( // R13 R14
        .pclk(pclk),
        .presetn(presetn),
        .set(cc1_set),
        .clr(1'b0),
        .wr_en(wr_req1),
        .wr_val(pwdata[pirq_pkg::REQ_CC1_BIT]),
        .flag_q(capcmp_one_flag)
    );
    sticky_flag u_tmr2 ( // R15
        .pclk(pclk),
        .presetn(presetn),
        .set(events.timer_two_match),
        .clr(1'b0),
        .wr_en(wr_req1),
        .wr_val(pwdata[pirq_pkg::REQ_TMR2_BIT]),
        .flag_q(timer_two_match_flag)
    );
    sticky_flag u_timer_one_count_reg ( // R16
        .pclk(pclk),
        .presetn(presetn),
        .set(events.timer_one_roll),
        .clr(1'b0),
        .wr_en(wr_req1),
        .wr_val(pwdata[pirq_pkg::REQ_TIMER_ONE_COUNT_REG_BIT]),
        .flag_q(timer_one_overflow_flag)
    );
    sticky_flag u_cc2 (
        .pclk(pclk),
        .presetn(presetn),
        .set(cc2_set),
        .clr(1'b0),
        .wr_en(wr_req2),
        .wr_val(pwdata[0]),
        .flag_q(capcmp_two_flag)
    );

    logic [7:0] request_1;
    assign request_1 = {timer_one_gate_flag, adc_done_flag, serial_rx_full_flag,
        serial_tx_empty_flag, sync_port_done_flag, capcmp_one_flag,
        timer_two_match_flag, timer_one_overflow_flag};

    // ----------------------------------------
    // Interrupt request
    // ----------------------------------------
    logic periph_any;
    logic irq_d;
    assign periph_any = (|(request_1 & peripheral_irq_enable_1_q))
        | (capcmp_two_flag & capcmp_two_enable_q);
    assign irq_d = global_irq_enable_q // R17
        & ((peripheral_group_enable_q & periph_any) // R3 R18
        | (timer_zero_enable_q & timer_zero_overflow_flag));

    // Registered request to the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request_q <= 1'b0;
        end else begin
            irq_request_q <= irq_d; // R18
        end
    end

    // ----------------------------------------
    // Event status, write one to clear
    // ----------------------------------------
    logic [9:0] ev_pulse;
    logic [9:0] ev_stat_q;
    logic [9:0] ev_mask_q;
    assign ev_pulse = {events.timer_zero_roll, events.adc_done, events.sync_done, cc1_set,
        events.timer_two_match, events.timer_one_roll, cc2_set,
        events.rx_full & ~serial_rx_full_flag, events.tx_empty & ~serial_tx_empty_flag,
        events.gate_active & timer_one_gate_flag};

    // Sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat_q <= pirq_pkg::RST_EVENT;
        end else if (wr && (paddr == pirq_pkg::OFS_EVENT_STAT)) begin
            ev_stat_q <= (ev_stat_q & ~pwdata[9:0]) | ev_pulse;
        end else begin
            ev_stat_q <= ev_stat_q | ev_pulse;
        end
    end

    // Mask register and level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_mask_q <= pirq_pkg::RST_EVENT;
            event_irq_q <= 1'b0;
        end else begin
            if (wr && (paddr == pirq_pkg::OFS_EVENT_MASK)) begin
                ev_mask_q <= pwdata[9:0];
            end
            event_irq_q <= |(ev_stat_q & ev_mask_q);
        end
    end

    // ----------------------------------------
    // Read data and response
    // ----------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            pirq_pkg::OFS_CONTROL: rd_d = {24'h000000, global_irq_enable_q,
                peripheral_group_enable_q, timer_zero_enable_q, 2'b00,
                timer_zero_overflow_flag, 2'b00};
            pirq_pkg::OFS_ENABLE_1: rd_d = {24'h000000, peripheral_irq_enable_1_q};
            pirq_pkg::OFS_ENABLE_2: rd_d = {31'h00000000, capcmp_two_enable_q}; // R7
            pirq_pkg::OFS_REQUEST_1: rd_d = {24'h000000, request_1};
            pirq_pkg::OFS_REQUEST_2: rd_d = {31'h00000000, capcmp_two_flag};
            pirq_pkg::OFS_EVENT_STAT: rd_d = {22'h000000, ev_stat_q};
            pirq_pkg::OFS_EVENT_MASK: rd_d = {22'h000000, ev_mask_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // One wait state: answer registered in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            prdata <= (rd & ~pready) ? rd_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_group_gates_irq: assert property (@(posedge pclk) disable iff (!presetn) // R3
        !peripheral_group_enable_q && !timer_zero_enable_q |=> !irq_request_q)
        else $error("irq raised with group disabled");
    a_global_gates_irq: assert property (@(posedge pclk) disable iff (!presetn) // R17
        !global_irq_enable_q |=> !irq_request_q)
        else $error("irq raised with global enable clear");
    a_adc_flag_sets: assert property (@(posedge pclk) disable iff (!presetn) // R9
        events.adc_done |=> adc_done_flag)
        else $error("adc flag not set");
    a_adc_flag_holds: assert property (@(posedge pclk) disable iff (!presetn) // R9
        adc_done_flag && !wr_req1 |=> adc_done_flag)
        else $error("adc flag lost without clear");
    a_t0_flag_sets: assert property (@(posedge pclk) disable iff (!presetn) // R1
        events.timer_zero_roll |=> timer_zero_overflow_flag)
        else $error("timer zero flag not set");
    a_gate_flag_level: assert property (@(posedge pclk) disable iff (!presetn) // R8
        events.gate_active |=> !timer_one_gate_flag)
        else $error("gate flag high while gate active");
    a_rx_read_clears: assert property (@(posedge pclk) disable iff (!presetn) // R10
        rx_data_read |=> !serial_rx_full_flag)
        else $error("rx flag not cleared by read");
    a_tx_write_clears: assert property (@(posedge pclk) disable iff (!presetn) // R11
        tx_data_write |=> !serial_tx_empty_flag)
        else $error("tx flag not cleared by write");
    a_pwm_no_flag: assert property (@(posedge pclk) disable iff (!presetn) // R14
        cc1_mode == pirq_pkg::CC_PWM && !capcmp_one_flag && !wr_req1 |=> !capcmp_one_flag)
        else $error("capcmp one flag set in pwm mode");
    a_tmr2_sets: assert property (@(posedge pclk) disable iff (!presetn) // R15 R4
        events.timer_two_match && !global_irq_enable_q |=> timer_two_match_flag)
        else $error("timer two flag not set");
    a_timer_one_count_reg_sets: assert property (@(posedge pclk) disable iff (!presetn) // R16
        events.timer_one_roll |=> timer_one_overflow_flag)
        else $error("timer one flag not set");
    a_sync_sets: assert property (@(posedge pclk) disable iff (!presetn) // R12
        events.sync_done |=> sync_port_done_flag)
        else $error("sync flag not set");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn) // R18
        global_irq_enable_q && peripheral_group_enable_q && adc_done_flag
        && peripheral_irq_enable_1_q[pirq_pkg::REQ_ADC_BIT] |=> irq_request_q)
        else $error("irq missing for enabled flag");
    a_enable2_reads: assert property (@(posedge pclk) disable iff (!presetn) // R7
        rd && !pready && paddr == pirq_pkg::OFS_ENABLE_2 |=> prdata[31:1] == 31'h00000000)
        else $error("enable two upper bits not zero");

endmodule

//--- bench/periph_source.sv
// Partner model: on-chip peripheral event sources and timer zero
`timescale 1ns/1ps
module periph_source (
    input wire logic pclk,
    input wire logic presetn,
    output pirq_pkg::periph_events_t events,
    output logic rx_data_read,
    output logic tx_data_write
);
    logic [11:0] pulse_q = 12'h000;
    logic [11:0] level_q = 12'h000;
    logic [7:0] t0_count_q = 8'h00;
    logic [7:0] t0_load_val = 8'h00;
    logic t0_load_q = 1'b0;
    logic t0_run_q = 1'b0;
    logic t0_roll_q = 1'b0;

    initial begin
        rx_data_read = 1'b0;
        tx_data_write = 1'b0;
    end

    // ----------------------------------------
    // Timer zero: ignores reset, so it keeps its count
    // ----------------------------------------
    always @(posedge pclk) begin
        if (t0_load_q) begin
            t0_count_q <= t0_load_val;
        end else if (t0_run_q) begin
            t0_count_q <= t0_count_q + 8'h01;
        end
        t0_roll_q <= t0_run_q && !t0_load_q && (t0_count_q == 8'hff);
    end

    // Pulses, levels and the rollover merged onto the event bus
    assign events = pirq_pkg::periph_events_t'(pulse_q | level_q | {t0_roll_q, 11'h000});

    // ----------------------------------------
    // Tasks called by the bench
    // ----------------------------------------
    task automatic pulse(input int idx);
        @(posedge pclk);
        pulse_q[idx] <= 1'b1;
        @(posedge pclk);
        pulse_q[idx] <= 1'b0;
    endtask

    task automatic set_level(input int idx, input logic v);
        @(posedge pclk);
        level_q[idx] <= v;
    endtask

    // Loading the count also decides whether it runs on
    task automatic t0_set(input logic [7:0] v, input logic run);
        @(posedge pclk);
        t0_load_q <= 1'b1;
        t0_load_val <= v;
        t0_run_q <= run;
        @(posedge pclk);
        t0_load_q <= 1'b0;
    endtask

    // Reading the data register empties the receive buffer
    task automatic read_rx();
        @(posedge pclk);
        rx_data_read <= 1'b1;
        level_q[8] <= 1'b0;
        @(posedge pclk);
        rx_data_read <= 1'b0;
    endtask

    // Writing the data register fills the transmit buffer
    task automatic write_tx();
        @(posedge pclk);
        tx_data_write <= 1'b1;
        level_q[7] <= 1'b0;
        @(posedge pclk);
        tx_data_write <= 1'b0;
    endtask
endmodule

//--- bench/tb_top.sv
// Testbench: registers, sticky flags and request gating of the interrupt block
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] A_CTL = pirq_pkg::OFS_CONTROL;
    localparam logic [7:0] A_EN1 = pirq_pkg::OFS_ENABLE_1;
    localparam logic [7:0] A_EN2 = pirq_pkg::OFS_ENABLE_2;
    localparam logic [7:0] A_REQ1 = pirq_pkg::OFS_REQUEST_1;
    localparam logic [7:0] A_REQ2 = pirq_pkg::OFS_REQUEST_2;
    localparam logic [7:0] A_STAT = pirq_pkg::OFS_EVENT_STAT;
    localparam logic [7:0] A_MASK = pirq_pkg::OFS_EVENT_MASK;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pirq_pkg::periph_events_t events;
    pirq_pkg::capcmp_mode_t cc1_mode = pirq_pkg::CC_CAPTURE;
    pirq_pkg::capcmp_mode_t cc2_mode = pirq_pkg::CC_CAPTURE;
    logic rx_data_read;
    logic tx_data_write;
    logic irq_request_q;
    logic event_irq_q;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int ev1[6] = '{9, 6, 5, 4, 3, 2};
    int rb1[6] = '{6, 3, 2, 2, 1, 0};
    logic [31:0] v;
    logic err;

    always #2.5 pclk = ~pclk;

    periph_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .cc1_mode(cc1_mode), .cc2_mode(cc2_mode),
        .rx_data_read(rx_data_read), .tx_data_write(tx_data_write),
        .irq_request_q(irq_request_q), .event_irq_q(event_irq_q));

    periph_source u_src (.pclk(pclk), .presetn(presetn), .events(events),
        .rx_data_read(rx_data_read), .tx_data_write(tx_data_write));

    // ----------------------------------------
    // Checking, verdict and hang guard
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, v, err);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, v, err);
        chk(what, v, exp);
    endtask

    task automatic irqchk(input logic exp);
        repeat (3) @(posedge pclk);
        chk("irq request", {31'h0, irq_request_q}, {31'h0, exp});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values; gate idle so its flag reads one
        rdchk("enable one reset", A_EN1, 32'h0);
        rdchk("enable two reset", A_EN2, 32'h0);
        rdchk("request one reset", A_REQ1, 32'h80);
        wr(A_EN1, 32'hff);
        rdchk("enable one rw", A_EN1, 32'hff);
        wr(A_EN2, 32'hff);
        rdchk("enable two rw", A_EN2, 32'h01);
        apb(1'b0, 8'h1c, 32'h0, v, err);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", v, 32'h0);
        // Flags set with every enable clear; they must hold
        wr(A_EN1, 32'h0);
        wr(A_EN2, 32'h0);
        for (int i = 0; i < 6; i++) begin
            cc1_mode <= (i == 3) ? pirq_pkg::CC_COMPARE : pirq_pkg::CC_CAPTURE;
            wr(A_REQ1, 32'h0);
            u_src.pulse(ev1[i]);
            repeat (3) @(posedge pclk);
            rdchk("flag set", A_REQ1, 32'h80 | (32'h1 << rb1[i]));
            rdchk("flag held", A_REQ1, 32'h80 | (32'h1 << rb1[i]));
            irqchk(1'b0);
        end
        wr(A_REQ1, 32'h0);
        cc1_mode <= pirq_pkg::CC_PWM;
        u_src.pulse(5);
        u_src.pulse(4);
        rdchk("pwm no flag", A_REQ1, 32'h80);
        for (int i = 0; i < 2; i++) begin
            cc2_mode <= (i == 0) ? pirq_pkg::CC_CAPTURE : pirq_pkg::CC_COMPARE;
            wr(A_REQ2, 32'h0);
            u_src.pulse(1 - i);
            rdchk("capcmp two flag", A_REQ2, 32'h1);
        end
        // Gate, receive and transmit levels
        u_src.set_level(10, 1'b1);
        rdchk("gate active", A_REQ1, 32'h00);
        u_src.set_level(10, 1'b0);
        wr(A_REQ1, 32'h30);
        rdchk("read-only bits", A_REQ1, 32'h80);
        u_src.set_level(8, 1'b1);
        rdchk("rx full", A_REQ1, 32'ha0);
        u_src.read_rx();
        rdchk("rx read", A_REQ1, 32'h80);
        u_src.set_level(7, 1'b1);
        rdchk("tx empty", A_REQ1, 32'h90);
        u_src.write_tx();
        rdchk("tx written", A_REQ1, 32'h80);
        // Request gating; flag cleared before enabling its source
        wr(A_REQ1, 32'h0);
        wr(A_EN1, 32'h40);
        u_src.pulse(9);
        wr(A_CTL, 32'h80);
        irqchk(1'b0);
        wr(A_CTL, 32'h40);
        irqchk(1'b0);
        wr(A_CTL, 32'hc0);
        irqchk(1'b1);
        wr(A_EN1, 32'h0);
        irqchk(1'b0);
        wr(A_EN1, 32'h40);
        wr(A_REQ1, 32'h0);
        irqchk(1'b0);
        // Timer zero rollover
        wr(A_CTL, 32'h0);
        u_src.t0_set(8'hfa, 1'b1);
        repeat (12) @(posedge pclk);
        rdchk("timer zero flag", A_CTL, 32'h04);
        wr(A_CTL, 32'ha4);
        irqchk(1'b1);
        u_src.t0_set(8'h00, 1'b0);
        wr(A_CTL, 32'ha0);
        irqchk(1'b0);
        rdchk("timer zero clear", A_CTL, 32'ha0);
        // Sticky event status, mask and its interrupt
        wr(A_CTL, 32'h0);
        wr(A_MASK, 32'h0);
        wr(A_STAT, 32'h3ff);
        u_src.pulse(9);
        rdchk("event status", A_STAT, 32'h100);
        chk("event irq masked", {31'h0, event_irq_q}, 32'h0);
        wr(A_MASK, 32'h100);
        repeat (3) @(posedge pclk);
        chk("event irq set", {31'h0, event_irq_q}, 32'h1);
        wr(A_STAT, 32'h100);
        rdchk("event cleared", A_STAT, 32'h0);
        repeat (3) @(posedge pclk);
        chk("event irq clear", {31'h0, event_irq_q}, 32'h0);
        // Mid-run reset returns the enables to zero
        wr(A_EN1, 32'h5a);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("enable one after reset", A_EN1, 32'h0);
        chk("irq after reset", {31'h0, irq_request_q}, 32'h0);
        give_verdict();
    end
endmodule
